//--- src/ssf_top.sv
// Purpose: Serial link slave with status reporting over APB
// Assumes: Link pins are asynchronous and sampled twice on pclk
// Notes:   Link runs clock idle low, data sampled on rising edge
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
// Contract
// RULE1 - Status bits 28-24 show receive queue fill count, meaningful in enhanced mode.
// RULE2 - Status bits 20-16 show transmit queue fill count, meaningful in enhanced mode.
// RULE3 - Bit 12 sets on a framing error, meaningful only in framed mode.
// RULE4 - Bit 11 is high while a transfer is in progress, low when idle; the code also holds it high while the transmit queue holds data.
// RULE5 - Bit 8 sets when transmit queue is empty at a framed word start.
// RULE6 - Underrun stays set until software writes zero or toggles module enable.
// RULE7 - Bit 7 is high when the shift register holds no data.
// RULE8 - A word completed while the receive store is full is dropped; overflow sets.
// RULE9 - Overflow is set by hardware only; cleared by writing zero or re-enabling.
// RULE10 - Bit 5 shows receive queue empty exactly when read and write pointers match.
// RULE11 - Unimplemented status bits, including 31-29 and 10-9, read as zero.
// RULE12 - Writes to read-only status fields are ignored; only flags respond.
module ssf_top #(
   parameter int DATA_W = ssf_pkg::SSF_DATA_W,
   parameter int DEPTH  = ssf_pkg::SSF_FIFO_DEPTH
) (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [ssf_pkg::SSF_ADDR_W-1:0] paddr,
   input  wire logic [31:0]                   pwdata,
   output var  logic [31:0]                   prdata,
   output var  logic                          pready,
   output var  logic                          pslverr,
   input  wire logic                          link_sck,
   input  wire logic                          link_ss_n,
   input  wire logic                          link_mosi,
   output var  logic                          link_miso
);

   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;

   typedef struct packed {
      logic              on;
      logic              enh;
      logic              frm;
      logic              sck_s1;
      logic              sck_s2;
      logic              sck_s3;
      logic              ss_n_s1;
      logic              ss_n_s2;
      logic              mosi_s1;
      logic              mosi_s2;
      ssf_pkg::ssf_link_t state;
      logic [2:0]        bitcnt;
      logic [DATA_W-1:0] rx_shift;
      logic [DATA_W-1:0] tx_shift;
      logic              loaded;
      logic              frm_err;
      logic              tx_unr;
      logic              rx_ovf;
      logic [PW-1:0]     rx_wptr;
      logic [PW-1:0]     rx_rptr;
      logic [PW-1:0]     tx_wptr;
      logic [PW-1:0]     tx_rptr;
      logic [31:0]       rdata;
   } ssf_state_t;

   ssf_state_t q;
   ssf_state_t d;

   logic [DATA_W-1:0] rx_rdata;
   logic [DATA_W-1:0] tx_rdata;
   logic [PW-1:0]     rx_cnt;
   logic [PW-1:0]     tx_cnt;
   logic              rx_empty;
   logic              rx_full;
   logic              tx_empty;
   logic              tx_full;
   logic              rx_push;
   logic              rx_pop;
   logic              tx_push;
   logic              tx_pop;
   logic              busy;
   logic              hit_ctrl;
   logic              hit_stat;
   logic              hit_data;
   logic              acc_wr;
   logic              acc_rd;
   logic              sck_rise;
   logic              sck_fall;
   logic              do_load;
   logic              ovf_set;
   logic              unr_set;
   logic              ferr_set;
   logic [DATA_W-1:0] rx_word;
   logic [31:0]       stat_word;
   logic [31:0]       ctrl_word;

   ssf_mem #(
      .W     (DATA_W),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_rx_mem (
      .clk   (pclk),
      .we    (rx_push),
      .waddr (q.rx_wptr[AW-1:0]),
      .wdata (rx_word),
      .raddr (d.rx_rptr[AW-1:0]),
      .rdata (rx_rdata)
   );

   ssf_mem #(
      .W     (DATA_W),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_tx_mem (
      .clk   (pclk),
      .we    (tx_push),
      .waddr (q.tx_wptr[AW-1:0]),
      .wdata (pwdata[DATA_W-1:0]),
      .raddr (d.tx_rptr[AW-1:0]),
      .rdata (tx_rdata)
   );

   assign hit_ctrl = (paddr == ssf_pkg::SSF_OFS_CTRL);
   assign hit_stat = (paddr == ssf_pkg::SSF_OFS_STAT);
   assign hit_data = (paddr == ssf_pkg::SSF_OFS_DATA);
   assign acc_wr   = psel & penable & pwrite;
   assign acc_rd   = psel & penable & ~pwrite;
   assign pready   = penable;
   assign pslverr  = psel & penable & ~(hit_ctrl | hit_stat | hit_data);
   assign prdata   = q.rdata;
   assign link_miso = q.tx_shift[DATA_W-1];

   assign rx_cnt   = q.rx_wptr - q.rx_rptr;
   assign tx_cnt   = q.tx_wptr - q.tx_rptr;
   // RULE10 pointer compare
   assign rx_empty = (q.rx_wptr == q.rx_rptr);
   assign tx_empty = (q.tx_wptr == q.tx_rptr);
   assign rx_full  = q.enh ? (rx_cnt == PW'(DEPTH)) : !rx_empty;
   assign tx_full  = q.enh ? (tx_cnt == PW'(DEPTH)) : !tx_empty;

   assign sck_rise = q.sck_s2 & ~q.sck_s3;
   assign sck_fall = ~q.sck_s2 & q.sck_s3;
   assign rx_word  = {q.rx_shift[DATA_W-2:0], q.mosi_s2};

   // RULE4 activity indicator
   assign busy = q.on & ((q.state == ssf_pkg::SSF_LINK_FRAME) | q.loaded | !tx_empty);

   always_comb
   begin
      ctrl_word = 32'h0000_0000;
      ctrl_word[ssf_pkg::SSF_CTRL_ON]  = q.on;
      ctrl_word[ssf_pkg::SSF_CTRL_ENH] = q.enh;
      ctrl_word[ssf_pkg::SSF_CTRL_FRM] = q.frm;
   end

   // RULE11 unused bits zero
   always_comb
   begin
      stat_word = 32'h0000_0000;
      // RULE1 receive fill count
      stat_word[ssf_pkg::SSF_ST_RXCNT +: ssf_pkg::SSF_CNT_W] = ssf_pkg::SSF_CNT_W'(rx_cnt);
      // RULE2 transmit fill count
      stat_word[ssf_pkg::SSF_ST_TXCNT +: ssf_pkg::SSF_CNT_W] = ssf_pkg::SSF_CNT_W'(tx_cnt);
      stat_word[ssf_pkg::SSF_ST_FRAMING_ERROR_FLAG] = q.frm_err;
      stat_word[ssf_pkg::SSF_ST_BUSY]   = busy;
      stat_word[ssf_pkg::SSF_ST_TUR]    = q.tx_unr;
      // RULE7 shifter empty view
      stat_word[ssf_pkg::SSF_ST_SHIFTER_EMPTY]   = ~q.loaded;
      stat_word[ssf_pkg::SSF_ST_ROV]    = q.rx_ovf;
      stat_word[ssf_pkg::SSF_ST_RBE]    = rx_empty;
   end

   always_comb
   begin
      d        = q;
      rx_push  = 1'b0;
      tx_pop   = 1'b0;
      do_load  = 1'b0;
      ovf_set  = 1'b0;
      unr_set  = 1'b0;
      ferr_set = 1'b0;
      tx_push  = acc_wr & hit_data & q.on & ~tx_full;
      rx_pop   = acc_rd & hit_data & ~rx_empty;

      // Pin synchronisers
      d.sck_s1  = link_sck;
      d.sck_s2  = q.sck_s1;
      d.sck_s3  = q.sck_s2;
      d.ss_n_s1 = link_ss_n;
      d.ss_n_s2 = q.ss_n_s1;
      d.mosi_s1 = link_mosi;
      d.mosi_s2 = q.mosi_s1;

      // Read data captured in the setup phase
      if (psel & ~penable)
      begin
         if (hit_ctrl)
         begin
            d.rdata = ctrl_word;
         end
         else if (hit_stat)
         begin
            d.rdata = stat_word;
         end
         else if (hit_data)
         begin
            d.rdata = 32'(rx_rdata);
         end
         else
         begin
            d.rdata = 32'h0000_0000;
         end
      end

      if (acc_wr & hit_ctrl)
      begin
         d.on  = pwdata[ssf_pkg::SSF_CTRL_ON];
         d.enh = pwdata[ssf_pkg::SSF_CTRL_ENH];
         d.frm = pwdata[ssf_pkg::SSF_CTRL_FRM];
      end

      unique case (q.state)
         ssf_pkg::SSF_LINK_IDLE:
         begin
            if (!q.ss_n_s2)
            begin
               d.state  = ssf_pkg::SSF_LINK_FRAME;
               d.bitcnt = ssf_pkg::SSF_BIT_FIRST;
               do_load  = 1'b1;
            end
         end
         ssf_pkg::SSF_LINK_FRAME:
         begin
            if (q.ss_n_s2)
            begin
               d.state  = ssf_pkg::SSF_LINK_IDLE;
               d.bitcnt = ssf_pkg::SSF_BIT_FIRST;
               d.loaded = 1'b0;
               // RULE3 frame cut short
               ferr_set = q.frm & (q.bitcnt != ssf_pkg::SSF_BIT_FIRST);
            end
            else if (sck_rise)
            begin
               d.rx_shift = rx_word;
               d.bitcnt   = q.bitcnt + 3'h1;
               if (q.bitcnt == ssf_pkg::SSF_BIT_LAST)
               begin
                  d.loaded = 1'b0;
                  // RULE8 drop on full store
                  rx_push  = ~rx_full;
                  ovf_set  = rx_full;
               end
            end
            else if (sck_fall)
            begin
               if (q.bitcnt == ssf_pkg::SSF_BIT_FIRST)
               begin
                  do_load = 1'b1;
               end
               else
               begin
                  d.tx_shift = {q.tx_shift[DATA_W-2:0], 1'b0};
               end
            end
         end
      endcase

      if (do_load)
      begin
         if (!tx_empty)
         begin
            d.tx_shift = tx_rdata;
            d.loaded   = 1'b1;
            tx_pop     = 1'b1;
         end
         else
         begin
            d.tx_shift = '0;
            // RULE5 empty queue at word start
            unr_set    = q.frm;
         end
      end

      if (rx_push)
      begin
         d.rx_wptr = q.rx_wptr + PW'(1);
      end
      if (rx_pop)
      begin
         d.rx_rptr = q.rx_rptr + PW'(1);
      end
      if (tx_push)
      begin
         d.tx_wptr = q.tx_wptr + PW'(1);
      end
      if (tx_pop)
      begin
         d.tx_rptr = q.tx_rptr + PW'(1);
      end

      // RULE12 only flags take status writes
      if (acc_wr & hit_stat)
      begin
         d.frm_err = q.frm_err & pwdata[ssf_pkg::SSF_ST_FRAMING_ERROR_FLAG];
         // RULE6 write zero clears
         d.tx_unr  = q.tx_unr & pwdata[ssf_pkg::SSF_ST_TUR];
         // RULE9 write zero clears
         d.rx_ovf  = q.rx_ovf & pwdata[ssf_pkg::SSF_ST_ROV];
      end
      // Set wins over a write-zero clear in the same cycle; a disable clear below wins over both
      d.frm_err = d.frm_err | ferr_set;
      d.tx_unr  = d.tx_unr | unr_set;
      d.rx_ovf  = d.rx_ovf | ovf_set;

      // RULE6 RULE9 disable clears flags
      if (!q.on)
      begin
         d.state    = ssf_pkg::SSF_LINK_IDLE;
         d.bitcnt   = ssf_pkg::SSF_BIT_FIRST;
         d.loaded   = 1'b0;
         d.tx_shift = '0;
         d.frm_err  = 1'b0;
         d.tx_unr   = 1'b0;
         d.rx_ovf   = 1'b0;
         d.rx_rptr  = q.rx_wptr;
         d.tx_rptr  = q.tx_wptr;
         rx_push    = 1'b0;
         tx_pop     = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q          <= '0;
         q.on       <= ssf_pkg::SSF_CTRL_RST;
         q.enh      <= ssf_pkg::SSF_CTRL_RST;
         q.frm      <= ssf_pkg::SSF_CTRL_RST;
         q.sck_s1   <= 1'b0;
         q.sck_s2   <= 1'b0;
         q.sck_s3   <= 1'b0;
         q.ss_n_s1  <= 1'b1;
         q.ss_n_s2  <= 1'b1;
         q.state    <= ssf_pkg::SSF_LINK_IDLE;
      end
      else
      begin
         q <= d;
      end
   end

endmodule : ssf_top
`default_nettype wire

//--- src/ssf_pkg.sv
// Purpose: Constants and types shared by the serial status block
// Assumes: 32-bit APB register access, byte addresses
// Notes:   Offsets of control, status and data words are fixed here
package ssf_pkg;

   localparam int          SSF_ADDR_W     = 12;
   localparam int          SSF_DATA_W     = 8;
   localparam int          SSF_FIFO_DEPTH = 16;
   localparam int          SSF_CNT_W      = 5;

   // Register byte offsets
   localparam logic [11:0] SSF_OFS_CTRL   = 12'h000;
   localparam logic [11:0] SSF_OFS_STAT   = 12'h004;
   localparam logic [11:0] SSF_OFS_DATA   = 12'h008;

   // Control field positions and reset value
   localparam int          SSF_CTRL_ENH   = 0;
   localparam int          SSF_CTRL_FRM   = 1;
   localparam int          SSF_CTRL_ON    = 15;
   localparam logic        SSF_CTRL_RST   = 1'b0;

   // Status field positions
   localparam int          SSF_ST_RXCNT   = 24;
   localparam int          SSF_ST_TXCNT   = 16;
   localparam int          SSF_ST_FRAMING_ERROR_FLAG  = 12;
   localparam int          SSF_ST_BUSY    = 11;
   localparam int          SSF_ST_TUR     = 8;
   localparam int          SSF_ST_SHIFTER_EMPTY    = 7;
   localparam int          SSF_ST_ROV     = 6;
   localparam int          SSF_ST_RBE     = 5;

   // Link bit counter
   localparam logic [2:0]  SSF_BIT_FIRST  = 3'h0;
   localparam logic [2:0]  SSF_BIT_LAST   = 3'h7;

   typedef enum logic [1:0]
   {
      SSF_LINK_IDLE  = 2'b00,
      SSF_LINK_FRAME = 2'b01
   } ssf_link_t;

endpackage : ssf_pkg

//--- src/ssf_mem.sv
// Purpose: Small word store for the receive and transmit queues
// Assumes: One write and one read port on one clock
// Notes:   Read data is registered and passes a same-cycle write through
`timescale 1ns/100ps
`default_nettype none
module ssf_mem #(
   parameter int W     = 8,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic [AW-1:0] raddr,
   output var  logic [W-1:0]  rdata
);

   logic [W-1:0] mem [DEPTH];

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      if (we && (waddr == raddr))
      begin
         rdata <= wdata;
      end
      else
      begin
         rdata <= mem[raddr];
      end
   end

endmodule : ssf_mem
`default_nettype wire

//--- verification/ssf_properties.sv
// Purpose: Port-level checks of the serial status block
// Assumes: Enable bit of the control word tracked from APB writes
// Notes:   Bound to ssf_top
`timescale 1ns/100ps
`default_nettype none
module ssf_properties #(
   parameter int DATA_W = 8,
   parameter int DEPTH  = 16
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        link_sck,
   input wire logic        link_ss_n,
   input wire logic        link_mosi,
   input wire logic        link_miso
);
   logic on_q;
   logic bad;
   assign bad = paddr != 12'h000 && paddr != 12'h004 && paddr != 12'h008;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         on_q <= 1'b0;
      else if (psel && penable && pwrite && paddr == ssf_pkg::SSF_OFS_CTRL)
         on_q <= pwdata[ssf_pkg::SSF_CTRL_ON];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_rd(logic [11:0] a);
      psel && penable && !pwrite && paddr == a;
   endsequence
   sequence s_bad_xfer;
      psel && !penable && bad ##1 psel && penable;
   endsequence
   a_ready_now: assert property (psel && penable |-> pready)
      else $error("pready late");
   a_status_gaps: assert property (s_rd(12'h004) |-> (prdata & 32'hE0E0E610) == 32'h0)
      else $error("status gap not zero");
   a_unmapped_err: assert property (s_bad_xfer |-> pslverr && prdata == 32'h0)
      else $error("unmapped access wrong");
   a_data_upper: assert property (s_rd(12'h008) |-> prdata[31:8] == 24'h0)
      else $error("data upper bits set");
   a_rx_count_max: assert property (s_rd(12'h004) |-> prdata[28:24] <= DEPTH)
      else $error("rx count too big");
   a_tx_count_max: assert property (s_rd(12'h004) |-> prdata[20:16] <= DEPTH)
      else $error("tx count too big");
   a_busy_off_low: assert property (s_rd(12'h004) and !on_q |-> !prdata[11])
      else $error("busy while off");
   a_flags_off_clear: assert property (s_rd(12'h004) and !on_q |-> (prdata & 32'h1F1F1140) == 0)
      else $error("flags or counts while off");
   a_empty_vs_count: assert property (s_rd(12'h004) and on_q |-> prdata[5] == (prdata[28:24] == 0))
      else $error("empty flag disagrees");
endmodule : ssf_properties
bind ssf_top ssf_properties #(.DATA_W(DATA_W), .DEPTH(DEPTH)) ssf_properties_i (.*);
`default_nettype wire

//--- verification/ssf_peer.sv
// Purpose: Link master standing at the far side
// Assumes: Mode 0, clock idle low, 400 ns period
// Notes:   Data line shows inverse of last bit when deselected
`timescale 1ns/100ps
`default_nettype none
module ssf_peer (
   output var  logic link_sck,
   output var  logic link_ss_n,
   output var  logic link_mosi,
   input  wire logic link_miso
);
   logic [7:0] got [0:31];
   initial
   begin
      link_sck  = 1'b0;
      link_ss_n = 1'b1;
      link_mosi = 1'b0;
   end
   // Frame of n words, last one cut to nb bits
   task automatic frame(input logic [7:0] first, input int n, input int nb);
      logic [7:0] b;
      // Edges kept off the pclk edges
      #10 link_ss_n = 1'b0;
      #400;
      for (int w = 0; w < n; w++)
      begin
         b = first + 8'(w);
         for (int i = 7; i >= 8 - ((w == n - 1) ? nb : 8); i--)
         begin
            link_mosi = b[i];
            #200 link_sck = 1'b1;
            got[w][i] = link_miso;
            #200 link_sck = 1'b0;
         end
      end
      #400 link_ss_n = 1'b1;
      link_mosi = ~link_mosi;
      #400;
   endtask : frame
endmodule : ssf_peer
`default_nettype wire

//--- verification/test_spi_status_flags.sv
// Purpose: Self-checking bench of the serial status block
// Assumes: Zero wait APB slave, peer model on the link
// Notes:   Each scenario is one task
`timescale 1ns/100ps
`default_nettype none
module test_spi_status_flags;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   wire logic   sck;
   wire logic   ss_n;
   wire logic   mosi;
   wire logic   miso;
   logic [31:0] q;
   logic        e;
   int          num_errors = 0;
   int          n_tests = 0;
   localparam logic [11:0] AC = ssf_pkg::SSF_OFS_CTRL;
   localparam logic [11:0] AS = ssf_pkg::SSF_OFS_STAT;
   localparam logic [11:0] AD = ssf_pkg::SSF_OFS_DATA;
   localparam logic [31:0] ON = 32'h8000;
   ssf_top ssf_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link_sck(sck), .link_ss_n(ss_n), .link_mosi(mosi),
      .link_miso(miso));
   ssf_peer ssf_peer_i (.link_sck(sck), .link_ss_n(ss_n), .link_mosi(mosi), .link_miso(miso));
   always #25 pclk = ~pclk;
   task automatic close_out;
      $display("tests %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         chk(32'h0, 32'h1);
         close_out();
      end
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [31:0] fld(input logic [31:0] v, input int p, input int w);
      return (v >> p) & ((32'h1 << w) - 32'h1);
   endfunction : fld
   task automatic t_reset;
      apb(0, AC, 0);
      chk(q, 32'h0);
      apb(0, 12'h00C, 0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      apb(1, AS, 32'hFFFFFFFF);
      apb(0, AS, 0);
      chk(q & 32'hFFFFFF5F, 32'h0);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_enh_rx;
      apb(1, AC, ON | 32'h1);
      fork
         ssf_peer_i.frame(8'h40, 17, 8);
         begin
            repeat (40) @(posedge pclk);
            apb(0, AS, 0);
            chk(fld(q, ssf_pkg::SSF_ST_BUSY, 1), 32'h1);
         end
      join
      apb(0, AS, 0);
      chk(fld(q, ssf_pkg::SSF_ST_RXCNT, 5), 32'h10);
      chk(fld(q, ssf_pkg::SSF_ST_BUSY, 1), 32'h0);
      chk(fld(q, ssf_pkg::SSF_ST_ROV, 1), 32'h1);
      chk(fld(q, ssf_pkg::SSF_ST_RBE, 1), 32'h0);
      for (int i = 0; i < 16; i++)
      begin
         apb(0, AD, 0);
         chk(q, 32'h40 + 32'(i));
      end
      apb(0, AS, 0);
      chk(fld(q, ssf_pkg::SSF_ST_RBE, 1), 32'h1);
      apb(1, AC, 32'h1);
      apb(1, AC, ON | 32'h1);
      apb(0, AS, 0);
      chk(fld(q, ssf_pkg::SSF_ST_ROV, 1), 32'h0);
      chk(fld(q, ssf_pkg::SSF_ST_SHIFTER_EMPTY, 1), 32'h1);
      $display("t_enh_rx done");
   endtask : t_enh_rx
   task automatic t_tx;
      apb(1, AD, 32'hA5);
      apb(1, AD, 32'h3C);
      apb(0, AS, 0);
      chk(fld(q, ssf_pkg::SSF_ST_TXCNT, 5), 32'h2);
      fork
         ssf_peer_i.frame(8'h00, 2, 8);
         begin
            repeat (40) @(posedge pclk);
            apb(0, AS, 0);
            chk(fld(q, ssf_pkg::SSF_ST_SHIFTER_EMPTY, 1), 32'h0);
            chk(fld(q, ssf_pkg::SSF_ST_TXCNT, 5), 32'h1);
         end
      join
      chk({24'h0, ssf_peer_i.got[0]}, 32'hA5);
      chk({24'h0, ssf_peer_i.got[1]}, 32'h3C);
      apb(0, AS, 0);
      chk(fld(q, ssf_pkg::SSF_ST_TXCNT, 5), 32'h0);
      $display("t_tx done");
   endtask : t_tx
   task automatic t_ovf;
      apb(1, AC, 0);
      apb(1, AC, ON);
      ssf_peer_i.frame(8'h11, 2, 8);
      apb(1, AS, 32'hFFFFFFFF);
      apb(0, AS, 0);
      chk(fld(q, ssf_pkg::SSF_ST_ROV, 1), 32'h1);
      apb(0, AD, 0);
      chk(q, 32'h11);
      apb(1, AS, 0);
      apb(0, AS, 0);
      chk(fld(q, ssf_pkg::SSF_ST_ROV, 1), 32'h0);
      $display("t_ovf done");
   endtask : t_ovf
   task automatic t_frm;
      apb(1, AC, 0);
      apb(1, AC, ON | 32'h2);
      ssf_peer_i.frame(8'h22, 1, 8);
      apb(0, AS, 0);
      chk(fld(q, ssf_pkg::SSF_ST_TUR, 1), 32'h1);
      apb(1, AS, 32'hFFFFFFFF);
      apb(0, AS, 0);
      chk(fld(q, ssf_pkg::SSF_ST_TUR, 1), 32'h1);
      ssf_peer_i.frame(8'h33, 1, 4);
      apb(0, AS, 0);
      chk(fld(q, ssf_pkg::SSF_ST_FRAMING_ERROR_FLAG, 1), 32'h1);
      apb(1, AS, 0);
      apb(0, AS, 0);
      chk(q & 32'h1100, 32'h0);
      ssf_peer_i.frame(8'h44, 1, 8);
      apb(1, AC, 0);
      apb(1, AC, ON | 32'h2);
      apb(0, AS, 0);
      chk(fld(q, ssf_pkg::SSF_ST_TUR, 1), 32'h0);
      $display("t_frm done");
   endtask : t_frm
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_enh_rx();
      t_tx();
      t_ovf();
      t_frm();
      close_out();
   end
   initial
   begin
      #500000;
      num_errors++;
      close_out();
   end
endmodule : test_spi_status_flags
`default_nettype wire
